// ---- rtl/eeprom_controller.sv ----
// Data EEPROM controller: register file, unlock, timed write, byte array.
`timescale 1ns/1ns
module eeprom_controller #(
  parameter int unsigned WRITE_CYCLES = eeprom_pkg::WRITE_CYCLES
) (
  input  wire logic     clk,
  input  wire logic     rst,
  input  wire logic     power_on_reset,
  input  wire logic     master_clear_reset,
  input  wire logic     watchdog_timeout,
  eeprom_sfr_if.device  sfr,
  output logic          write_done_flag,
  output logic          write_busy
);

  localparam logic [19:0] HALF_CYCLES = 20'((WRITE_CYCLES + 1) / 2);

  logic [7:0] mem_q [eeprom_pkg::DEPTH];

  logic [7:0] address_q;
  logic [7:0] data_q;
  logic [7:0] rdata_q;
  logic       memory_sel_q;
  logic       config_sel_q;
  logic       rd_strobe_q;
  logic       wr_strobe_q;
  logic       write_permit_q;
  logic       abort_error_q;
  logic       done_flag_q;
  logic [19:0] timer_q;
  eeprom_pkg::unlock_state_type unlock_q;
  eeprom_pkg::prog_state_type   prog_q;

  wire soft_reset = master_clear_reset | watchdog_timeout;
  wire writing    = (prog_q != eeprom_pkg::PROG_IDLE);

  wire w_addr = sfr.wr_en & (sfr.sel == eeprom_pkg::SEL_ADDRESS);
  wire w_data = sfr.wr_en & (sfr.sel == eeprom_pkg::SEL_DATA);
  wire w_ctrl = sfr.wr_en & (sfr.sel == eeprom_pkg::SEL_CONTROL);
  wire w_unlk = sfr.wr_en & (sfr.sel == eeprom_pkg::SEL_UNLOCK);

  wire req_rd = w_ctrl & sfr.wdata[eeprom_pkg::BIT_RD_STROBE];
  wire req_wr = w_ctrl & sfr.wdata[eeprom_pkg::BIT_WR_STROBE];
  wire data_space = ~sfr.wdata[eeprom_pkg::BIT_MEMORY_SEL]
                  & ~sfr.wdata[eeprom_pkg::BIT_CONFIG_SEL];

  // start checks; permit must already be set.
  wire start_wr = req_wr & ~writing & write_permit_q
                & (unlock_q == eeprom_pkg::UNLOCK_ARMED) & data_space;
  wire start_rd = req_rd & ~writing & data_space;
  wire timer_end = (timer_q == 20'h00001);

  // unlock sequence; any other write disarms it.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      unlock_q <= eeprom_pkg::UNLOCK_IDLE;
    end else if (w_unlk && sfr.wdata == eeprom_pkg::UNLOCK_KEY_ONE) begin
      unlock_q <= eeprom_pkg::UNLOCK_FIRST;
    end else if (w_unlk && sfr.wdata == eeprom_pkg::UNLOCK_KEY_TWO
                 && unlock_q == eeprom_pkg::UNLOCK_FIRST) begin
      unlock_q <= eeprom_pkg::UNLOCK_ARMED;
    end else if (sfr.wr_en || soft_reset) begin
      unlock_q <= eeprom_pkg::UNLOCK_IDLE;
    end
  end

  // zero on reset; locked while writing; plain storage.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      address_q <= eeprom_pkg::REG_RESET;
    end else if (soft_reset) begin
      address_q <= eeprom_pkg::REG_RESET;
    end else if (w_addr && !writing) begin
      address_q <= sfr.wdata;
    end
  end

  // data kept until a soft reset, a read or a software write.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      data_q <= eeprom_pkg::REG_RESET;
    end else if (soft_reset) begin
      data_q <= eeprom_pkg::REG_RESET;
    end else if (start_rd) begin
      data_q <= mem_q[address_q];
    end else if (w_data && !writing) begin
      data_q <= sfr.wdata;
    end
  end

  // permit clears at power-up or by a software write, never by hardware.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      write_permit_q <= 1'b0;
    end else if (power_on_reset) begin
      write_permit_q <= 1'b0;
    end else if (w_ctrl && !writing) begin
      write_permit_q <= sfr.wdata[eeprom_pkg::BIT_WRITE_PERMIT];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      memory_sel_q <= 1'b0;
      config_sel_q <= 1'b0;
    end else if (w_ctrl && !writing) begin
      memory_sel_q <= sfr.wdata[eeprom_pkg::BIT_MEMORY_SEL];
      config_sel_q <= sfr.wdata[eeprom_pkg::BIT_CONFIG_SEL];
    end
  end

  // read strobe lasts one cycle, then hardware clears it.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_strobe_q <= 1'b0;
    end else begin
      rd_strobe_q <= start_rd;
    end
  end

  // abort error on reset mid-write; software may clear it.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      abort_error_q <= 1'b0;
    end else if (soft_reset && writing) begin
      abort_error_q <= 1'b1;
    end else if (w_ctrl && !writing
                 && !sfr.wdata[eeprom_pkg::BIT_ABORT_ERROR]) begin
      abort_error_q <= 1'b0;
    end
  end

  // done flag is sticky; the set wins over a clear.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      done_flag_q <= 1'b0;
    end else if (prog_q == eeprom_pkg::PROG_WRITE && timer_end) begin
      done_flag_q <= 1'b1;
    end else if (w_ctrl && !sfr.wdata[eeprom_pkg::BIT_DONE_FLAG]) begin
      done_flag_q <= 1'b0;
    end
  end

  // timed erase then program, halves of the write time.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prog_q      <= eeprom_pkg::PROG_IDLE;
      timer_q     <= 20'h00000;
      wr_strobe_q <= 1'b0;
    end else if (soft_reset) begin
      prog_q      <= eeprom_pkg::PROG_IDLE;
      timer_q     <= 20'h00000;
      wr_strobe_q <= 1'b0;
    end else begin
      case (prog_q)
        eeprom_pkg::PROG_IDLE: begin
          if (start_wr) begin
            prog_q      <= eeprom_pkg::PROG_ERASE;
            timer_q     <= HALF_CYCLES;
            wr_strobe_q <= 1'b1;
          end
        end
        eeprom_pkg::PROG_ERASE: begin
          if (timer_end) begin
            prog_q  <= eeprom_pkg::PROG_WRITE;
            timer_q <= HALF_CYCLES;
          end else begin
            timer_q <= timer_q - 20'h00001;
          end
        end
        eeprom_pkg::PROG_WRITE: begin
          if (timer_end) begin
            prog_q      <= eeprom_pkg::PROG_IDLE;
            wr_strobe_q <= 1'b0;
          end else begin
            timer_q <= timer_q - 20'h00001;
          end
        end
        default: begin
          prog_q <= eeprom_pkg::PROG_IDLE;
        end
      endcase
    end
  end

  // erase leaves ones, then the new byte is programmed.
  always_ff @(posedge clk) begin
    if (prog_q == eeprom_pkg::PROG_ERASE && timer_end && !soft_reset) begin
      mem_q[address_q] <= 8'hff;
    end else if (prog_q == eeprom_pkg::PROG_WRITE && timer_end
                 && !soft_reset) begin
      mem_q[address_q] <= data_q;
    end
  end

  wire [7:0] control_view = {memory_sel_q, config_sel_q, 1'b0, done_flag_q,
                             abort_error_q, write_permit_q, wr_strobe_q,
                             rd_strobe_q};

  wire [7:0] read_mux = (sfr.sel == eeprom_pkg::SEL_ADDRESS) ? address_q :
                        (sfr.sel == eeprom_pkg::SEL_DATA)    ? data_q :
                        (sfr.sel == eeprom_pkg::SEL_CONTROL) ? control_view :
                                                              8'h00;

  // Read data is registered so the core sees a stable byte next cycle.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_q <= 8'h00;
    end else if (sfr.rd_en) begin
      rdata_q <= read_mux;
    end
  end

  assign sfr.rdata       = rdata_q;
  assign sfr.busy        = writing;
  assign write_done_flag = done_flag_q;
  assign write_busy      = writing;

endmodule // eeprom_controller

// ---- rtl/eeprom_core_port.sv ----
// Core-side driver that runs read and unlocked write sequences.
`timescale 1ns/1ns
module eeprom_core_port (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       req_read,
  input  wire logic       req_write,
  input  wire logic [7:0] req_addr,
  input  wire logic [7:0] req_data,
  eeprom_sfr_if.core      sfr,
  output logic            req_ready,
  output logic [7:0]      read_data,
  output logic            read_valid
);

  logic [2:0] step_q;
  logic       is_write_q;
  logic [7:0] addr_q;
  logic [7:0] data_q;
  logic       read_valid_q;
  logic       wr_en_q;
  logic       rd_en_q;
  logic [1:0] sel_q;
  logic [7:0] wdata_q;

  localparam logic [7:0] PERMIT = 8'h01 << eeprom_pkg::BIT_WRITE_PERMIT;
  localparam logic [7:0] STROBE = 8'h01 << eeprom_pkg::BIT_WR_STROBE;
  localparam logic [7:0] RDSTB  = 8'h01 << eeprom_pkg::BIT_RD_STROBE;
  // Keep the done flag bit set so control writes never clear it.
  localparam logic [7:0] KEEP   = 8'h01 << eeprom_pkg::BIT_DONE_FLAG;

  wire idle = (step_q == 3'h0);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      step_q       <= 3'h0;
      is_write_q   <= 1'b0;
      addr_q       <= 8'h00;
      data_q       <= 8'h00;
      read_valid_q <= 1'b0;
      wr_en_q      <= 1'b0;
      rd_en_q      <= 1'b0;
      sel_q        <= 2'h0;
      wdata_q      <= 8'h00;
    end else begin
      read_valid_q <= 1'b0;
      wr_en_q      <= 1'b0;
      rd_en_q      <= 1'b0;
      case (step_q)
        3'h0: begin
          if ((req_read || req_write) && req_ready) begin
            is_write_q <= req_write;
            addr_q     <= req_addr;
            data_q     <= req_data;
            step_q     <= 3'h1;
          end
        end
        3'h1: begin
          wr_en_q <= 1'b1;
          sel_q   <= eeprom_pkg::SEL_ADDRESS;
          wdata_q <= addr_q;
          step_q  <= is_write_q ? 3'h2 : 3'h6;
        end
        3'h2: begin
          wr_en_q <= 1'b1;
          sel_q   <= eeprom_pkg::SEL_DATA;
          wdata_q <= data_q;
          step_q  <= 3'h3;
        end
        // permit set three cycles before the strobe
        3'h3: begin
          wr_en_q <= 1'b1;
          sel_q   <= eeprom_pkg::SEL_CONTROL;
          wdata_q <= PERMIT | KEEP;
          step_q  <= 3'h4;
        end
        // first key, kept atomic by hardware sequencing
        3'h4: begin
          wr_en_q <= 1'b1;
          sel_q   <= eeprom_pkg::SEL_UNLOCK;
          wdata_q <= eeprom_pkg::UNLOCK_KEY_ONE;
          step_q  <= 3'h5;
        end
        3'h5: begin
          wr_en_q <= 1'b1;
          sel_q   <= eeprom_pkg::SEL_UNLOCK;
          wdata_q <= eeprom_pkg::UNLOCK_KEY_TWO;
          step_q  <= 3'h7;
        end
        3'h6: begin
          wr_en_q <= 1'b1;
          rd_en_q <= 1'b1;
          sel_q   <= eeprom_pkg::SEL_CONTROL;
          wdata_q <= RDSTB | KEEP;
          step_q  <= 3'h0;
          is_write_q <= 1'b0;
        end
        3'h7: begin
          wr_en_q <= 1'b1;
          sel_q   <= eeprom_pkg::SEL_CONTROL;
          wdata_q <= PERMIT | STROBE | KEEP;
          step_q  <= 3'h0;
        end
        default: begin
          step_q <= 3'h0;
        end
      endcase
      if (rd_en_q && sel_q == eeprom_pkg::SEL_CONTROL) begin
        // Fetch the data register in the following cycle.
        rd_en_q <= 1'b1;
        sel_q   <= eeprom_pkg::SEL_DATA;
        step_q  <= 3'h0;
      end
      if (rd_en_q && sel_q == eeprom_pkg::SEL_DATA) begin
        read_valid_q <= 1'b1;
      end
    end
  end

  assign sfr.wr_en   = wr_en_q;
  assign sfr.rd_en   = rd_en_q;
  assign sfr.sel     = sel_q;
  assign sfr.wdata   = wdata_q;
  // A strobe still on the port has not raised busy yet, so it is waited out;
  // a request taken then would see its register writes refused.
  assign req_ready   = idle & ~sfr.busy & ~wr_en_q & ~rd_en_q;
  assign read_data   = sfr.rdata;
  assign read_valid  = read_valid_q;

endmodule // eeprom_core_port

// ---- rtl/eeprom_pkg.sv ----
// Shared constants and types for the data EEPROM access controller.
package eeprom_pkg;

  localparam int unsigned ADDR_W      = 8;
  localparam int unsigned DATA_W      = 8;
  localparam int unsigned DEPTH       = 256;

  // Register select codes on the special function register port.
  localparam logic [1:0] SEL_ADDRESS  = 2'h0;
  localparam logic [1:0] SEL_DATA     = 2'h1;
  localparam logic [1:0] SEL_CONTROL  = 2'h2;
  localparam logic [1:0] SEL_UNLOCK   = 2'h3;

  // Control register bit positions.
  localparam int unsigned BIT_RD_STROBE    = 0;
  localparam int unsigned BIT_WR_STROBE    = 1;
  localparam int unsigned BIT_WRITE_PERMIT = 2;
  localparam int unsigned BIT_ABORT_ERROR  = 3;
  localparam int unsigned BIT_DONE_FLAG    = 4;
  localparam int unsigned BIT_CONFIG_SEL   = 6;
  localparam int unsigned BIT_MEMORY_SEL   = 7;

  localparam logic [7:0] UNLOCK_KEY_ONE = 8'h55;
  localparam logic [7:0] UNLOCK_KEY_TWO = 8'haa;
  localparam logic [7:0] REG_RESET      = 8'h00;

  // Write time in microseconds and its cycle count at 100 MHz.
  localparam int unsigned WRITE_TIME_US  = 4000;
  localparam int unsigned CLK_MHZ        = 100;
  localparam int unsigned WRITE_CYCLES   = WRITE_TIME_US * CLK_MHZ;
  localparam int unsigned TIMER_W        = 20;

  typedef enum logic [1:0] {
    UNLOCK_IDLE  = 2'h0,
    UNLOCK_FIRST = 2'h1,
    UNLOCK_ARMED = 2'h3
  } unlock_state_type;

  typedef enum logic [1:0] {
    PROG_IDLE  = 2'h0,
    PROG_ERASE = 2'h1,
    PROG_WRITE = 2'h3
  } prog_state_type;

endpackage

// ---- rtl/eeprom_sfr_if.sv ----
// Special function register port joining core software and the controller.
`timescale 1ns/1ns
interface eeprom_sfr_if;
  logic       wr_en;
  logic       rd_en;
  logic [1:0] sel;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       busy;

  modport device (
    input  wr_en,
    input  rd_en,
    input  sel,
    input  wdata,
    output rdata,
    output busy
  );

  modport core (
    output wr_en,
    output rd_en,
    output sel,
    output wdata,
    input  rdata,
    input  busy
  );
endinterface

// ---- verif/eeprom_chk.sv ----
// Concurrent checks on the register port between core port and controller.
`timescale 1ns/1ns
module eeprom_chk #(
  parameter int unsigned WRITE_CYCLES = 20
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       wr_en,
  input  wire logic       rd_en,
  input  wire logic [1:0] sel,
  input  wire logic [7:0] wdata,
  input  wire logic [7:0] rdata,
  input  wire logic       busy
);
  logic [20:0] busy_cnt_q;
  logic [20:0] busy_cnt_d;
  logic        ctl_wr;

  // The counter restarts at every idle cycle, so it measures one write only.
  assign busy_cnt_d = busy ? busy_cnt_q + 21'h1 : 21'h0;
  assign ctl_wr     = wr_en && sel == eeprom_pkg::SEL_CONTROL;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) busy_cnt_q <= 21'h0;
    else busy_cnt_q <= busy_cnt_d;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_unlock_reads_zero: assert property (
    rd_en && sel == eeprom_pkg::SEL_UNLOCK |=> rdata == 8'h00)
    else $error("unlock port read is not zero");
  a_start_by_strobe: assert property (
    $rose(busy) |-> $past(ctl_wr) && $past(wdata[1]))
    else $error("write started without a strobe write");
  a_busy_long_enough: assert property (
    $fell(busy) |-> busy_cnt_q >= WRITE_CYCLES)
    else $error("write ended before its timer ran out");
  a_busy_not_overlong: assert property (
    busy |-> busy_cnt_q <= WRITE_CYCLES)
    else $error("write ran past its timer");
  a_read_value_holds: assert property (
    !rd_en |=> $stable(rdata))
    else $error("read value changed without a read");
  a_strobe_idle_clear: assert property (
    rd_en && sel == eeprom_pkg::SEL_CONTROL && !busy
      && !$past(busy) |=> !rdata[eeprom_pkg::BIT_WR_STROBE])
    else $error("write strobe seen set while idle");
  a_read_selects_clear: assert property (
    ctl_wr && wdata[0] |-> !wdata[7] && !wdata[6])
    else $error("read strobe set with a select bit");
  a_read_data_follows: assert property (
    ctl_wr && wdata[0] |-> ##[1:2] (rd_en && sel == eeprom_pkg::SEL_DATA))
    else $error("data not fetched after read strobe");

  cover property ($rose(busy));
  cover property ($fell(busy));
  cover property (rd_en && sel == eeprom_pkg::SEL_DATA);
endmodule // eeprom_chk

// ---- verif/tb.sv ----
// Bench: core port and controller paired, plus a directly driven controller.
`timescale 1ns/1ns
module tb;
  localparam int unsigned WCYC = 20;
  localparam logic [1:0] SA = eeprom_pkg::SEL_ADDRESS;
  localparam logic [1:0] SD = eeprom_pkg::SEL_DATA;
  localparam logic [1:0] SC = eeprom_pkg::SEL_CONTROL;
  localparam logic [1:0] SU = eeprom_pkg::SEL_UNLOCK;
  logic       clk;
  logic       rst;
  logic       req_read;
  logic       req_write;
  logic [7:0] req_addr;
  logic [7:0] req_data;
  logic       req_ready;
  logic [7:0] read_data;
  logic       read_valid;
  logic       por_2;
  logic       mcr_2;
  logic       wdt_2;
  logic       done_1;
  logic       done_2;
  logic [7:0] v;
  int         n_errors;
  int         tests_run;

  eeprom_sfr_if bus_a();
  eeprom_sfr_if bus_b();
  eeprom_controller #(.WRITE_CYCLES(WCYC)) i_eeprom_controller (
    .clk(clk), .rst(rst), .power_on_reset(1'b0), .master_clear_reset(1'b0),
    .watchdog_timeout(1'b0), .sfr(bus_a), .write_done_flag(done_1),
    .write_busy());
  eeprom_core_port i_eeprom_core_port (
    .clk(clk), .rst(rst), .req_read(req_read), .req_write(req_write),
    .req_addr(req_addr), .req_data(req_data), .sfr(bus_a),
    .req_ready(req_ready), .read_data(read_data), .read_valid(read_valid));
  // The second controller is driven straight from the bench so that broken
  // unlock sequences and resets in mid-write can be forced.
  eeprom_controller #(.WRITE_CYCLES(WCYC)) i_eeprom_controller_b (
    .clk(clk), .rst(rst), .power_on_reset(por_2), .master_clear_reset(mcr_2),
    .watchdog_timeout(wdt_2), .sfr(bus_b), .write_done_flag(done_2),
    .write_busy());
  eeprom_chk #(.WRITE_CYCLES(WCYC)) i_eeprom_chk (
    .clk(clk), .rst(rst), .wr_en(bus_a.wr_en), .rd_en(bus_a.rd_en),
    .sel(bus_a.sel), .wdata(bus_a.wdata), .rdata(bus_a.rdata),
    .busy(bus_a.busy));

  task automatic report_and_stop();
    $display("errors %0d comparisons %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic fail_out();
    n_errors++;
    report_and_stop();
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr2(input logic [1:0] s, input logic [7:0] d);
    @(posedge clk);
    bus_b.wr_en <= 1'b1;
    bus_b.sel   <= s;
    bus_b.wdata <= d;
    @(posedge clk);
    bus_b.wr_en <= 1'b0;
  endtask
  task automatic rd2(input logic [1:0] s);
    @(posedge clk);
    bus_b.rd_en <= 1'b1;
    bus_b.sel   <= s;
    @(posedge clk);
    bus_b.rd_en <= 1'b0;
    #1 v = bus_b.rdata;
  endtask
  task automatic busy_is(input logic [7:0] e);
    #1 chk({7'h00, bus_b.busy}, e);
  endtask
  task automatic keys();
    // keys one after the other, no write between.
    wr2(SU, eeprom_pkg::UNLOCK_KEY_ONE);
    wr2(SU, eeprom_pkg::UNLOCK_KEY_TWO);
  endtask
  task automatic start2(input logic [7:0] a, input logic [7:0] d);
    wr2(SA, a);
    wr2(SD, d);
    wr2(SC, 8'h04);
    keys();
    wr2(SC, 8'h06);
  endtask
  task automatic wait2();
    for (int i = 0; i < 100; i++) begin
      @(posedge clk);
      #1 if (bus_b.busy === 1'b0) return;
    end
    fail_out();
  endtask
  // The request stands until an edge at which the port shows ready.
  task automatic issue(input logic rd, input logic wr, input logic [7:0] a,
                       input logic [7:0] d);
    logic ok;
    @(posedge clk);
    req_read  <= rd;
    req_write <= wr;
    req_addr  <= a;
    req_data  <= d;
    for (int i = 0; i < 100; i++) begin
      #1 ok = req_ready;
      @(posedge clk);
      if (ok === 1'b1) begin
        req_read  <= 1'b0;
        req_write <= 1'b0;
        return;
      end
    end
    fail_out();
  endtask
  task automatic do_write(input logic [7:0] a, input logic [7:0] d);
    issue(1'b0, 1'b1, a, d);
  endtask
  task automatic do_read(input logic [7:0] a, input logic [7:0] e);
    issue(1'b1, 1'b0, a, 8'h00);
    for (int i = 0; i < 20; i++) begin
      @(posedge clk);
      #1 if (read_valid === 1'b1) begin
        chk(read_data, e);
        return;
      end
    end
    fail_out();
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    rst = 1'b1;
    {req_read, req_write, req_addr, req_data} = 18'h0;
    {bus_b.wr_en, bus_b.rd_en, bus_b.sel, bus_b.wdata} = 12'h0;
    {por_2, mcr_2, wdt_2} = 3'h0;
    {n_errors, tests_run, v} = '0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    do_write(8'h00, 8'hc3);
    do_write(8'hff, 8'h3c);
    do_write(8'h00, 8'h0f);
    do_read(8'h00, 8'h0f);
    do_read(8'hff, 8'h3c);
    chk({7'h00, done_1}, 8'h01);
    rd2(SU);
    chk(v, 8'h00);
    wr2(SA, 8'h40);
    wr2(SD, 8'h99);
    keys();
    wr2(SC, 8'h02);
    busy_is(8'h00);
    keys();
    wr2(SC, 8'h06);
    busy_is(8'h00);
    wr2(SU, 8'haa);
    wr2(SU, 8'h55);
    wr2(SC, 8'h06);
    busy_is(8'h00);
    wr2(SU, 8'h55);
    wr2(SA, 8'h40);
    wr2(SU, 8'haa);
    wr2(SC, 8'h06);
    busy_is(8'h00);
    start2(8'h10, 8'h5a);
    busy_is(8'h01);
    wr2(SA, 8'h20);
    wr2(SC, 8'h04);
    rd2(SC);
    chk(v & 8'h02, 8'h02);
    rd2(SA);
    chk(v, 8'h10);
    wait2();
    rd2(SC);
    chk(v & 8'h16, 8'h14);
    chk({7'h00, done_2}, 8'h01);
    wr2(SC, 8'h04);
    rd2(SC);
    chk(v & 8'h10, 8'h00);
    wr2(SC, 8'h05);
    rd2(SD);
    chk(v, 8'h5a);
    rd2(SC);
    chk(v & 8'h01, 8'h00);
    rd2(SD);
    chk(v, 8'h5a);
    wr2(SD, 8'h77);
    rd2(SD);
    chk(v, 8'h77);
    for (int k = 0; k < 2; k++) begin
      start2(8'h30, 8'h11);
      @(posedge clk);
      mcr_2 <= (k == 0);
      wdt_2 <= (k == 1);
      @(posedge clk);
      {mcr_2, wdt_2} <= 2'h0;
      rd2(SC);
      chk(v & 8'h08, 8'h08);
      rd2(SA);
      chk(v, 8'h00);
      rd2(SD);
      chk(v, 8'h00);
      wr2(SC, 8'h04);
    end
    @(posedge clk);
    por_2 <= 1'b1;
    @(posedge clk);
    por_2 <= 1'b0;
    rd2(SC);
    chk(v & 8'h04, 8'h00);
    report_and_stop();
  end
endmodule // tb
